// ### verilog/usart_sync_pkg.sv
package usart_sync_pkg;
    // register offsets
    localparam logic [7:0] OFS_FLAGS = 8'h0C;
    localparam logic [7:0] OFS_RX_STATUS = 8'h18;
    localparam logic [7:0] OFS_TX_BUFFER = 8'h19;
    localparam logic [7:0] OFS_RX_BUFFER = 8'h1A;
    localparam logic [7:0] OFS_ENABLES = 8'h8C;
    localparam logic [7:0] OFS_TX_STATUS = 8'h98;
    localparam logic [7:0] OFS_BAUD = 8'h99;
    // transmit status register fields
    localparam int TX_CLOCK_SOURCE_BIT = 7;
    localparam int TX_NINE_BIT = 6;
    localparam int TX_ENABLE_BIT = 5;
    localparam int TX_SYNC_BIT = 4;
    localparam int TX_SHIFT_EMPTY_BIT = 1;
    localparam int TX_NINTH_VALUE_BIT = 0;
    // receive status register fields
    localparam int RX_PORT_ENABLE_BIT = 7;
    localparam int RX_NINE_BIT = 6;
    localparam int RX_SINGLE_BIT = 5;
    localparam int RX_CONTINUOUS_BIT = 4;
    localparam int RX_OVERRUN_BIT = 1;
    localparam int RX_NINTH_VALUE_BIT = 0;
    // flag and enable register fields
    localparam int RX_FULL_BIT = 5;
    localparam int TX_EMPTY_BIT = 4;
    // reset values
    localparam logic [7:0] TX_STATUS_RESET = 8'h02;
    localparam logic [7:0] REG_RESET = 8'h00;
    // word sizes and receive fifo depth
    localparam logic [3:0] BITS_SHORT = 4'h8;
    localparam logic [3:0] BITS_LONG = 4'h9;
    localparam int RX_FIFO_DEPTH = 2;

    function automatic logic [3:0] word_bits(input logic nine);
        word_bits = nine ? BITS_LONG : BITS_SHORT;
    endfunction

    // lsb-first shifter leaves an 8-bit word in the upper bits
    function automatic logic [8:0] align_word(input logic [8:0] sh, input logic nine);
        align_word = nine ? sh : {1'b0, sh[8:1]};
    endfunction
endpackage

// ### verilog/sync_link_if.sv
`timescale 1ns/1ps
interface sync_link_if;
    logic ck_o;
    logic ck_oe;
    logic dt_m_o;
    logic dt_m_oe;
    logic dt_s_o;
    logic dt_s_oe;
    logic ck;
    logic dt;

    // idle clock reads low, idle data is pulled high
    assign ck = ck_oe ? ck_o : 1'b0;
    assign dt = dt_m_oe ? dt_m_o : (dt_s_oe ? dt_s_o : 1'b1);

    modport master (output ck_o, output ck_oe, output dt_m_o, output dt_m_oe, input ck, input dt);
    modport slave (input ck, input dt, output dt_s_o, output dt_s_oe);
endinterface

// ### verilog/usart_sync_master.sv
`timescale 1ns/1ps
// Overview of operation
// - transmit and receive never run together
// - sync bit and port enable claim pins
// - clock source bit makes us drive clock
// - shifter loads buffer after last bit
// - buffer empty flag clears only on write
// - shifter empty bit readable, polled only
// - first bit on rising edge, stable falling
// - baud generator held idle when all disabled
// - load then enable also starts; back-to-back
// - dropping transmit enable aborts and resets
// - receive enable pauses transmit, frees data
// - single receive self-clears, transmit resumes
// - ninth transmit bit latched at load
// - receive enabled by either bit, falling sample
// - single gives one word, continuous wins
// - finished word enters fifo, sets flag
// - receive flag clears when fifo empty
// - third word with full fifo sets overrun
// - overrun blocks fifo until continuous cleared
// - ninth received bit follows each fifo word
// - software sets up transmit in given order
// - software clears receive bits before enabling
module usart_sync_master (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // serial link
    sync_link_if.master link
);
    typedef struct packed {
        logic clock_source_master;
        logic tx9;
        logic transmit_enable;
        logic sync_mode;
        logic transmit_ninth_value;
        logic port_enable;
        logic rx9;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic overrun_error;
        logic transmit_irq_enable;
        logic receive_irq_enable;
        logic [7:0] divisor;
        logic [7:0] baud_generator;
        logic ck;
        logic [7:0] tx_buf;
        logic buf_full;
        logic [8:0] transmit_shift_register;
        logic tsr_full;
        logic [3:0] tx_cnt;
        logic [8:0] receive_shift_register;
        logic [3:0] rx_cnt;
        logic [1:0][8:0] fifo;
        logic [1:0] fifo_cnt;
        logic [1:0] dt_sync;
        logic dt_o;
        logic dt_oe;
        logic ck_oe;
        logic [7:0] rdata;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    logic rx_mode;
    logic tx_mode;
    logic brg_run;
    logic tick;
    logic rise;
    logic fall;
    logic [3:0] tx_bits;
    logic [3:0] rx_bits;
    logic [8:0] rx_shift;
    logic [8:0] rx_word;

    // clock enable and data sample stay with the synced copies only
    assign rx_mode = s_r.single_receive_enable | s_r.continuous_receive_enable;
    assign tx_mode = s_r.transmit_enable & ~rx_mode;
    assign tx_bits = usart_sync_pkg::word_bits(s_r.tx9);
    assign rx_bits = usart_sync_pkg::word_bits(s_r.rx9);
    assign rx_shift = {s_r.dt_sync[1], s_r.receive_shift_register[8:1]};
    assign rx_word = usart_sync_pkg::align_word(rx_shift, s_r.rx9);

    always_comb begin
        s_nxt = s_r;
        s_nxt.dt_sync = {s_r.dt_sync[0], link.dt};
        brg_run = s_r.port_enable & s_r.sync_mode & s_r.clock_source_master & (s_r.transmit_enable | s_r.continuous_receive_enable | s_r.single_receive_enable);
        tick = 1'b0;
        if (!brg_run) begin
            s_nxt.baud_generator = 8'h00;
            s_nxt.ck = 1'b0;
        end else if (s_r.baud_generator == 8'h00) begin
            s_nxt.baud_generator = s_r.divisor;
            tick = 1'b1;
        end else begin
            s_nxt.baud_generator = s_r.baud_generator - 8'h01;
        end
        // the clock only toggles while a word moves, or to finish a high phase
        if (tick && ((tx_mode && s_r.tsr_full) || rx_mode || s_r.ck)) begin
            s_nxt.ck = ~s_r.ck;
        end
        rise = tick & ~s_r.ck & s_nxt.ck;
        fall = tick & s_r.ck & ~s_nxt.ck;

        if (!s_r.transmit_enable) begin
            s_nxt.tsr_full = 1'b0;
            s_nxt.tx_cnt = 4'h0;
        end else if (tx_mode) begin
            if (!s_r.tsr_full && s_r.buf_full) begin
                s_nxt.transmit_shift_register = {s_r.transmit_ninth_value, s_r.tx_buf};
                s_nxt.tsr_full = 1'b1;
                s_nxt.buf_full = 1'b0;
                s_nxt.tx_cnt = 4'h0;
            end else if (s_r.tsr_full && rise && s_r.tx_cnt != tx_bits) begin
                s_nxt.dt_o = s_r.transmit_shift_register[0];
                s_nxt.transmit_shift_register = {1'b0, s_r.transmit_shift_register[8:1]};
                s_nxt.tx_cnt = s_r.tx_cnt + 4'h1;
            // last bit held over its falling edge, then shifter empties
            end else if (s_r.tsr_full && fall && s_r.tx_cnt == tx_bits) begin
                s_nxt.tsr_full = 1'b0;
            end
        end

        if (!rx_mode) begin
            s_nxt.rx_cnt = 4'h0;
        end else if (fall) begin
            s_nxt.receive_shift_register = rx_shift;
            s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
            if (s_r.rx_cnt + 4'h1 == rx_bits) begin
                s_nxt.rx_cnt = 4'h0;
                // single receive ends after one word
                // then transmit resumes if still enabled
                if (!s_r.continuous_receive_enable) begin
                    s_nxt.single_receive_enable = 1'b0;
                end
            end
        end

        s_nxt.rdata = 8'h00;
        if (rd) begin
            case (addr)
                usart_sync_pkg::OFS_FLAGS: begin
                    s_nxt.rdata[usart_sync_pkg::TX_EMPTY_BIT] = ~s_r.buf_full;
                    s_nxt.rdata[usart_sync_pkg::RX_FULL_BIT] = s_r.fifo_cnt != 2'd0;
                end
                usart_sync_pkg::OFS_RX_STATUS: begin
                    s_nxt.rdata[usart_sync_pkg::RX_PORT_ENABLE_BIT] = s_r.port_enable;
                    s_nxt.rdata[usart_sync_pkg::RX_NINE_BIT] = s_r.rx9;
                    s_nxt.rdata[usart_sync_pkg::RX_SINGLE_BIT] = s_r.single_receive_enable;
                    s_nxt.rdata[usart_sync_pkg::RX_CONTINUOUS_BIT] = s_r.continuous_receive_enable;
                    s_nxt.rdata[usart_sync_pkg::RX_OVERRUN_BIT] = s_r.overrun_error;
                    s_nxt.rdata[usart_sync_pkg::RX_NINTH_VALUE_BIT] = s_r.fifo[0][8];
                end
                usart_sync_pkg::OFS_TX_BUFFER: s_nxt.rdata = s_r.tx_buf;
                usart_sync_pkg::OFS_RX_BUFFER: begin
                    s_nxt.rdata = s_r.fifo[0][7:0];
                    if (s_r.fifo_cnt != 2'd0) begin
                        s_nxt.fifo[0] = s_r.fifo[1];
                        s_nxt.fifo_cnt = s_r.fifo_cnt - 2'd1;
                    end
                end
                usart_sync_pkg::OFS_ENABLES: begin
                    s_nxt.rdata[usart_sync_pkg::TX_EMPTY_BIT] = s_r.transmit_irq_enable;
                    s_nxt.rdata[usart_sync_pkg::RX_FULL_BIT] = s_r.receive_irq_enable;
                end
                usart_sync_pkg::OFS_TX_STATUS: begin
                    s_nxt.rdata[usart_sync_pkg::TX_CLOCK_SOURCE_BIT] = s_r.clock_source_master;
                    s_nxt.rdata[usart_sync_pkg::TX_NINE_BIT] = s_r.tx9;
                    s_nxt.rdata[usart_sync_pkg::TX_ENABLE_BIT] = s_r.transmit_enable;
                    s_nxt.rdata[usart_sync_pkg::TX_SYNC_BIT] = s_r.sync_mode;
                    s_nxt.rdata[usart_sync_pkg::TX_SHIFT_EMPTY_BIT] = ~s_r.tsr_full;
                    s_nxt.rdata[usart_sync_pkg::TX_NINTH_VALUE_BIT] = s_r.transmit_ninth_value;
                end
                usart_sync_pkg::OFS_BAUD: s_nxt.rdata = s_r.divisor;
                default: s_nxt.rdata = 8'h00;
            endcase
        end

        if (wr) begin
            case (addr)
                usart_sync_pkg::OFS_RX_STATUS: begin
                    s_nxt.port_enable = wdata[usart_sync_pkg::RX_PORT_ENABLE_BIT];
                    s_nxt.rx9 = wdata[usart_sync_pkg::RX_NINE_BIT];
                    s_nxt.single_receive_enable = wdata[usart_sync_pkg::RX_SINGLE_BIT];
                    s_nxt.continuous_receive_enable = wdata[usart_sync_pkg::RX_CONTINUOUS_BIT];
                    if (!wdata[usart_sync_pkg::RX_CONTINUOUS_BIT]) begin
                        s_nxt.overrun_error = 1'b0;
                    end
                end
                usart_sync_pkg::OFS_TX_BUFFER: begin
                    // write while shifter empty moves next cycle
                    s_nxt.tx_buf = wdata;
                    s_nxt.buf_full = 1'b1;
                end
                usart_sync_pkg::OFS_ENABLES: begin
                    s_nxt.transmit_irq_enable = wdata[usart_sync_pkg::TX_EMPTY_BIT];
                    s_nxt.receive_irq_enable = wdata[usart_sync_pkg::RX_FULL_BIT];
                end
                usart_sync_pkg::OFS_TX_STATUS: begin
                    s_nxt.clock_source_master = wdata[usart_sync_pkg::TX_CLOCK_SOURCE_BIT];
                    s_nxt.tx9 = wdata[usart_sync_pkg::TX_NINE_BIT];
                    s_nxt.transmit_enable = wdata[usart_sync_pkg::TX_ENABLE_BIT];
                    s_nxt.sync_mode = wdata[usart_sync_pkg::TX_SYNC_BIT];
                    s_nxt.transmit_ninth_value = wdata[usart_sync_pkg::TX_NINTH_VALUE_BIT];
                end
                usart_sync_pkg::OFS_BAUD: s_nxt.divisor = wdata;
                default: begin
                end
            endcase
        end

        // word completion after register writes so overrun set wins
        if (rx_mode && fall && s_r.rx_cnt + 4'h1 == rx_bits) begin
            // full fifo on last bit loses word
            if (s_nxt.fifo_cnt == 2'(usart_sync_pkg::RX_FIFO_DEPTH)) begin
                s_nxt.overrun_error = 1'b1;
            end else if (!s_r.overrun_error) begin
                s_nxt.fifo[s_nxt.fifo_cnt[0]] = rx_word;
                s_nxt.fifo_cnt = s_nxt.fifo_cnt + 2'd1;
            end
        end

        // pins belong to port only in sync mode
        s_nxt.ck_oe = s_nxt.port_enable & s_nxt.sync_mode & s_nxt.clock_source_master & (s_nxt.transmit_enable | s_nxt.single_receive_enable | s_nxt.continuous_receive_enable);
        s_nxt.dt_oe = s_nxt.port_enable & s_nxt.sync_mode & s_nxt.transmit_enable & ~(s_nxt.single_receive_enable | s_nxt.continuous_receive_enable);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.dt_sync <= 2'b11;
            s_r.dt_o <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign link.ck_o = s_r.ck;
    assign link.ck_oe = s_r.ck_oe;
    assign link.dt_m_o = s_r.dt_o;
    assign link.dt_m_oe = s_r.dt_oe;
endmodule

// ### verilog/sync_serial_slave.sv
`timescale 1ns/1ps
module sync_serial_slave (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link
    sync_link_if.slave link,
    // user side
    input wire logic nine_bit,
    input wire logic talk,
    input wire logic [8:0] tx_word,
    output logic tx_taken,
    output logic [8:0] rx_word,
    output logic rx_valid
);
    typedef struct packed {
        logic [1:0] ck_sync;
        logic ck_last;
        logic [1:0] dt_sync;
        logic talk_last;
        logic [8:0] sh;
        logic [3:0] cnt;
        logic dt_o;
        logic dt_oe;
        logic tx_taken;
        logic [8:0] rx_word;
        logic rx_valid;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    logic rise;
    logic fall;
    logic [3:0] nbits;

    assign nbits = usart_sync_pkg::word_bits(nine_bit);

    always_comb begin
        s_nxt = s_r;
        s_nxt.ck_sync = {s_r.ck_sync[0], link.ck};
        s_nxt.dt_sync = {s_r.dt_sync[0], link.dt};
        s_nxt.ck_last = s_r.ck_sync[1];
        s_nxt.talk_last = talk;
        s_nxt.tx_taken = 1'b0;
        s_nxt.rx_valid = 1'b0;
        rise = s_r.ck_sync[1] & ~s_r.ck_last;
        fall = ~s_r.ck_sync[1] & s_r.ck_last;
        // one direction at a time, chosen by talk
        s_nxt.dt_oe = talk;
        // a change of direction restarts word framing
        if (talk != s_r.talk_last) begin
            s_nxt.cnt = 4'h0;
        // we mirror the master, driving after rising edges
        end else if (talk && rise) begin
            if (s_r.cnt == 4'h0) begin
                s_nxt.dt_o = tx_word[0];
                s_nxt.sh = {1'b0, tx_word[8:1]};
                s_nxt.tx_taken = 1'b1;
            end else begin
                s_nxt.dt_o = s_r.sh[0];
                s_nxt.sh = {1'b0, s_r.sh[8:1]};
            end
            s_nxt.cnt = (s_r.cnt + 4'h1 == nbits) ? 4'h0 : s_r.cnt + 4'h1;
        end else if (!talk && fall) begin
            s_nxt.sh = {s_r.dt_sync[1], s_r.sh[8:1]};
            if (s_r.cnt + 4'h1 == nbits) begin
                s_nxt.cnt = 4'h0;
                // ninth bit kept with its word
                s_nxt.rx_word = usart_sync_pkg::align_word(s_nxt.sh, nine_bit);
                s_nxt.rx_valid = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.dt_sync <= 2'b11;
            s_r.dt_o <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.dt_s_o = s_r.dt_o;
    assign link.dt_s_oe = s_r.dt_oe;
    assign tx_taken = s_r.tx_taken;
    assign rx_word = s_r.rx_word;
    assign rx_valid = s_r.rx_valid;
endmodule

// ### verification/usart_sync_props.sv
`timescale 1ns/1ps
module usart_sync_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link signals
    input wire logic ck_o,
    input wire logic ck_oe,
    input wire logic dt_m_o,
    input wire logic dt_m_oe,
    input wire logic dt_s_o,
    input wire logic dt_s_oe,
    input wire logic ck,
    input wire logic dt
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_ck_rise;
        $rose(ck_o);
    endsequence
    sequence s_ck_fall;
        $fell(ck_o);
    endsequence

    a_reset_quiet: assert property ($rose(rst_n) |-> !ck_oe && !dt_m_oe && !dt_s_oe)
        else $error("link driven right after reset");
    a_data_needs_clk: assert property (dt_m_oe |-> ck_oe)
        else $error("data driven without clock");
    a_no_fight: assert property (!(dt_m_oe && dt_s_oe))
        else $error("both ends drive data");
    a_gen_held: assert property ((!ck_oe) [*2] |-> !$rose(ck_o))
        else $error("clock edge while generator held");
    // bench divisor 7 gives 8-cycle phases; abort may cut a phase short
    a_half_min: assert property (s_ck_rise |=> ($stable(ck_o) || !ck_oe) [*6])
        else $error("clock high phase too short");
    a_high_bounded: assert property ($rose(ck) |-> ##[1:40] !ck)
        else $error("clock stuck high");
    a_tx_hold_fall: assert property ((s_ck_fall ##0 dt_m_oe) |-> $stable(dt_m_o))
        else $error("data moved at falling clock");
    a_slave_hold: assert property ((s_ck_fall ##0 dt_s_oe) |=> ($stable(dt_s_o) || !dt_s_oe) [*3])
        else $error("slave data moved at sample");
endmodule

// ### verification/usart_sync_master_bench.sv
`timescale 1ns/1ps
module usart_sync_master_bench;
    logic clk;
    logic rst_n;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic nine_bit;
    logic talk;
    logic [8:0] tx_word;
    logic tx_taken;
    logic [8:0] rx_word;
    logic rx_valid;
    logic [7:0] r;
    logic [8:0] w;
    int fail_count;
    int n_checks;

    sync_link_if lk();
    usart_sync_master usart_sync_master_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .link(lk.master));
    sync_serial_slave sync_serial_slave_inst (.clk(clk), .rst_n(rst_n), .link(lk.slave), .nine_bit(nine_bit),
        .talk(talk), .tx_word(tx_word), .tx_taken(tx_taken), .rx_word(rx_word), .rx_valid(rx_valid));
    usart_sync_props usart_sync_props_inst (.clk(clk), .rst_n(rst_n), .ck_o(lk.ck_o), .ck_oe(lk.ck_oe),
        .dt_m_o(lk.dt_m_o), .dt_m_oe(lk.dt_m_oe), .dt_s_o(lk.dt_s_o), .dt_s_oe(lk.dt_s_oe), .ck(lk.ck), .dt(lk.dt));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic wrap_up();
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic timeout();
        fail_count++;
        $display("BAD %0t wait ran out", $time);
        wrap_up();
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // gap cycle after each strobe keeps one assignment per time step
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        rreg(a, r);
        check({1'b0, r & m}, {1'b0, e});
    endtask

    task automatic poll(input logic [7:0] a, input logic [7:0] m);
        int i;
        for (i = 0; i < 600; i++) begin
            rreg(a, r);
            if ((r & m) === m) begin
                return;
            end
        end
        timeout();
    endtask

    // sel high waits for the slave taking a word, low for a word received
    task automatic await(input logic sel);
        int i;
        i = 0;
        do begin
            @(posedge clk);
            #1;
            i++;
        end while ((sel ? tx_taken : rx_valid) !== 1'b1 && i < 2000);
        if ((sel ? tx_taken : rx_valid) !== 1'b1) begin
            timeout();
        end
    endtask

    // samples the wire at each falling clock, first bit into bit 0
    task automatic grab(input int n, output logic [8:0] v);
        int i;
        int k;
        logic p;
        v = '0;
        k = 0;
        p = lk.ck;
        for (i = 0; i < 3000 && k < n; i++) begin
            @(negedge clk);
            if (p && !lk.ck) begin
                v[k] = lk.dt;
                k++;
            end
            p = lk.ck;
        end
        if (k < n) begin
            timeout();
        end
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        idle(5);
        rst_n <= 1'b1;
    endtask

    task automatic setup(input logic [7:0] tx);
        wreg(8'h99, 8'h07);
        wreg(8'h18, 8'h80);
        wreg(8'h98, tx);
    endtask

    task automatic t_reset_regs();
        logic [7:0] a [8] = '{8'h0C, 8'h18, 8'h19, 8'h1A, 8'h8C, 8'h98, 8'h99, 8'h55};
        logic [7:0] e [8] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
        wreg(8'h0C, 8'h00);
        wreg(8'h55, 8'hFF);
        foreach (a[i]) begin
            rchk(a[i], 8'hFF, e[i]);
        end
        wreg(8'h8C, 8'h30);
        rchk(8'h8C, 8'hFF, 8'h30);
    endtask

    task automatic t_tx_b2b();
        nine_bit <= 1'b0;
        setup(8'hB0);
        wreg(8'h19, 8'hA5);
        wreg(8'h19, 8'h3C);
        rchk(8'h0C, 8'h10, 8'h00);
        rchk(8'h98, 8'hFF, 8'hB0);
        await(1'b0);
        check(rx_word, 9'h0A5);
        await(1'b0);
        check(rx_word, 9'h03C);
        idle(20);
        rchk(8'h98, 8'hFF, 8'hB2);
        rchk(8'h0C, 8'hFF, 8'h10);
        wreg(8'h98, 8'h90);
    endtask

    // data loaded first, enable set afterwards
    task automatic t_tx_nine();
        wreg(8'h98, 8'hD1);
        wreg(8'h19, 8'h81);
        wreg(8'h98, 8'hF1);
        grab(9, w);
        check(w, 9'h181);
        idle(40);
        wreg(8'h98, 8'h90);
    endtask

    task automatic t_abort();
        setup(8'hB0);
        wreg(8'h19, 8'hFF);
        idle(40);
        wreg(8'h98, 8'h90);
        idle(3);
        #1;
        check({7'h00, lk.ck_oe, lk.dt_m_oe}, 9'h000);
        rchk(8'h98, 8'hFF, 8'h92);
        do_reset();
    endtask

    task automatic t_rx_single();
        nine_bit <= 1'b1;
        talk <= 1'b1;
        tx_word <= 9'h1C3;
        setup(8'h90);
        rchk(8'h18, 8'h30, 8'h00);
        wreg(8'h18, 8'hE0);
        poll(8'h0C, 8'h20);
        rchk(8'h18, 8'hFF, 8'hC1);
        rchk(8'h1A, 8'hFF, 8'hC3);
        idle(300);
        rchk(8'h0C, 8'h20, 8'h00);
    endtask

    // third word lands on a full fifo
    task automatic t_rx_overrun();
        tx_word <= 9'h101;
        wreg(8'h18, 8'hD0);
        await(1'b1);
        @(posedge clk);
        tx_word <= 9'h0A2;
        await(1'b1);
        @(posedge clk);
        tx_word <= 9'h1B3;
        poll(8'h18, 8'h02);
        rchk(8'h18, 8'hFF, 8'hD3);
        rchk(8'h1A, 8'hFF, 8'h01);
        rchk(8'h18, 8'hFF, 8'hD2);
        rchk(8'h1A, 8'hFF, 8'hA2);
        idle(300);
        rchk(8'h0C, 8'h20, 8'h00);
        wreg(8'h18, 8'hC0);
        rchk(8'h18, 8'h02, 8'h00);
        talk <= 1'b0;
        do_reset();
    endtask

    // slave stays silent, so the pulled-up line reads all ones
    task automatic t_rx_over_tx();
        nine_bit <= 1'b0;
        setup(8'hB0);
        wreg(8'h19, 8'h66);
        idle(40);
        wreg(8'h18, 8'hA0);
        idle(3);
        #1;
        check({7'h00, lk.ck_oe, lk.dt_m_oe}, 9'h002);
        rchk(8'h98, 8'hFF, 8'hB0);
        poll(8'h0C, 8'h20);
        rchk(8'h18, 8'hFF, 8'h80);
        check({8'h00, lk.dt_m_oe}, 9'h001);
        rchk(8'h1A, 8'hFF, 8'hFF);
    endtask

    initial begin
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        nine_bit = 1'b0;
        talk = 1'b0;
        tx_word = 9'h000;
        fail_count = 0;
        n_checks = 0;
        idle(5);
        rst_n <= 1'b1;
        t_reset_regs();
        t_tx_b2b();
        t_tx_nine();
        t_abort();
        t_rx_single();
        t_rx_overrun();
        t_rx_over_tx();
        wrap_up();
    end
endmodule
